// ### hdl/interval_timer.sv
// Functional notes
// - power off: unit clock stopped, writes ignored
// - power on: writes accepted, channels stopped
// - enabling output while stopped keeps pin steady
// - start trigger sets active, reads zero
// - period loads on next count clock
// - first load irq and toggle if mode bit
// - count down, reload period at zero
// - zero detected: irq and toggle output
// - period writable at any time while powered
// - down counter always readable
// - output enable writable while running; value only for disabled bits
// - stop trigger clears active, reads zero
// - stop freezes counter value
// - stop keeps output level
// - output disabled: pin follows software value
// - enabled while stopped: pin shows value bit
// - power off resets all channel registers
// - power off clears value, port mode
// - mode bit zero: quiet first load
// - new period applies from next reload
//
// Local design decisions: the address map and the address-and-strobe port.
`include "interval_timer_map.svh"
`timescale 1ns/1ps
`default_nettype none

module interval_timer #(
    parameter int NUM_CH = 4,
    parameter int CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [NUM_CH-1:0] channel_interrupt,
    output logic [NUM_CH-1:0] timer_pin_out,
    output logic [NUM_CH-1:0] timer_pin_oe
);
    // ---------------------------------------------
    // reset release
    // ---------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ---------------------------------------------
    // unit power and write gating
    // ---------------------------------------------
    logic unit_power_enable_ff;
    logic wr_ok;

    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            unit_power_enable_ff <= 1'b0;
        end else if (reg_wr && reg_addr == `TMR_UNIT_CTRL) begin
            unit_power_enable_ff <= reg_wdata[`TMR_POWER_BIT];
        end
    end

    assign wr_ok = reg_wr && unit_power_enable_ff;

    logic [3:0] grp;
    logic [1:0] sel_ch;
    logic addr_lo_ok;
    assign grp = reg_addr[7:4];
    assign sel_ch = reg_addr[3:2];
    assign addr_lo_ok = reg_addr[1:0] == 2'h0;

    // ---------------------------------------------
    // prescaler
    // ---------------------------------------------
    logic [7:0] prescaler_select_register_ff;
    logic [15:0] ps_cnt_ff;
    logic [15:0] mask0;
    logic [15:0] mask1;
    logic prescaled_clock_0;
    logic prescaled_clock_1;

    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            prescaler_select_register_ff <= `TMR_PS_RST;
        end else if (!unit_power_enable_ff) begin
            prescaler_select_register_ff <= `TMR_PS_RST;
        end else if (wr_ok && reg_addr == `TMR_PRESCALE) begin
            prescaler_select_register_ff <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ps_cnt_ff <= 16'h0000;
        end else if (!unit_power_enable_ff) begin
            ps_cnt_ff <= 16'h0000;
        end else begin
            ps_cnt_ff <= ps_cnt_ff + 16'h0001;
        end
    end

    // divide by 2^select; select 0 ticks every cycle
    assign mask0 = 16'((32'h1 << prescaler_select_register_ff[`TMR_PS_W-1:0]) - 32'h1);
    assign mask1 = 16'((32'h1 << prescaler_select_register_ff[`TMR_PS1_LSB+:`TMR_PS_W])
        - 32'h1);
    assign prescaled_clock_0 = unit_power_enable_ff && ((ps_cnt_ff & mask0) == mask0);
    assign prescaled_clock_1 = unit_power_enable_ff && ((ps_cnt_ff & mask1) == mask1);

    // ---------------------------------------------
    // start and stop triggers
    // ---------------------------------------------
    logic [NUM_CH-1:0] start_hit;
    logic [NUM_CH-1:0] stop_hit;
    logic [NUM_CH-1:0] upper_map;

    always_comb begin
        upper_map = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (i == 1) begin
                upper_map[i] = reg_wdata[`TMR_UPPER_CH1_BIT];
            end else if (i == 3) begin
                upper_map[i] = reg_wdata[`TMR_UPPER_CH3_BIT];
            end
        end
    end

    assign start_hit = (wr_ok && reg_addr == `TMR_START) ?
        (reg_wdata[NUM_CH-1:0] | upper_map) : '0;
    assign stop_hit = (wr_ok && reg_addr == `TMR_STOP) ?
        (reg_wdata[NUM_CH-1:0] | upper_map) : '0;

    // ---------------------------------------------
    // channels
    // ---------------------------------------------
    logic [NUM_CH-1:0] ch_event;
    logic [NUM_CH-1:0] channel_active_flag;
    logic [CNT_W-1:0] cnt_vec [NUM_CH];
    logic [15:0] mode_vec [NUM_CH];
    logic [CNT_W-1:0] period_vec [NUM_CH];

    for (genvar gi = 0; gi < NUM_CH; gi++) begin : ch
        interval_timer_pkg::ch_state_e state_ff;
        logic [15:0] channel_mode_register_ff;
        logic [CNT_W-1:0] period_register_ff;
        logic [CNT_W-1:0] down_counter_ff;
        logic count_tick;
        logic wr_here;

        assign wr_here = wr_ok && addr_lo_ok && sel_ch == 2'(gi);
        assign count_tick = channel_mode_register_ff[`TMR_MODE_CKS_BIT] ?
            prescaled_clock_1 : prescaled_clock_0;

        always_ff @(posedge sys_clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                channel_mode_register_ff <= `TMR_REG16_RST;
            end else if (!unit_power_enable_ff) begin
                channel_mode_register_ff <= `TMR_REG16_RST;
            end else if (wr_here && grp == `TMR_GRP_MODE) begin
                channel_mode_register_ff <= reg_wdata[15:0];
            end
        end

        always_ff @(posedge sys_clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                period_register_ff <= '0;
            end else if (!unit_power_enable_ff) begin
                period_register_ff <= '0;
            end else if (wr_here && grp == `TMR_GRP_PERIOD) begin
                period_register_ff <= reg_wdata[CNT_W-1:0];
            end
        end

        always_ff @(posedge sys_clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                state_ff <= interval_timer_pkg::CH_IDLE;
            end else if (!unit_power_enable_ff) begin
                state_ff <= interval_timer_pkg::CH_IDLE;
            end else if (stop_hit[gi]) begin
                state_ff <= interval_timer_pkg::CH_IDLE;
            end else if (start_hit[gi]) begin
                state_ff <= interval_timer_pkg::CH_LOAD;
            end else begin
                case (state_ff)
                    interval_timer_pkg::CH_IDLE: begin
                        state_ff <= interval_timer_pkg::CH_IDLE;
                    end
                    interval_timer_pkg::CH_LOAD: begin
                        if (count_tick) begin
                            state_ff <= interval_timer_pkg::CH_RUN;
                        end
                    end
                    interval_timer_pkg::CH_RUN: begin
                        state_ff <= interval_timer_pkg::CH_RUN;
                    end
                    default: begin
                        state_ff <= interval_timer_pkg::CH_IDLE;
                    end
                endcase
            end
        end

        always_ff @(posedge sys_clk or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                down_counter_ff <= '0;
            end else if (!unit_power_enable_ff) begin
                down_counter_ff <= '0;
            end else if (count_tick && !stop_hit[gi] && !start_hit[gi]) begin
                if (state_ff == interval_timer_pkg::CH_LOAD) begin
                    down_counter_ff <= period_register_ff;
                end else if (state_ff == interval_timer_pkg::CH_RUN) begin
                    if (down_counter_ff == '0) begin
                        down_counter_ff <= period_register_ff;
                    end else begin
                        down_counter_ff <= down_counter_ff - 1'b1;
                    end
                end
            end
        end

        // first load event by mode bit
        assign ch_event[gi] = count_tick && !stop_hit[gi] && !start_hit[gi] &&
            ((state_ff == interval_timer_pkg::CH_LOAD &&
              channel_mode_register_ff[`TMR_MODE_SIM_BIT]) ||
             (state_ff == interval_timer_pkg::CH_RUN && down_counter_ff == '0));
        assign channel_active_flag[gi] = state_ff != interval_timer_pkg::CH_IDLE;
        assign cnt_vec[gi] = down_counter_ff;
        assign mode_vec[gi] = channel_mode_register_ff;
        assign period_vec[gi] = period_register_ff;
    end

    // ---------------------------------------------
    // output control
    // ---------------------------------------------
    logic [NUM_CH-1:0] output_value_register_ff;
    logic [NUM_CH-1:0] output_enable_register_ff;
    logic [NUM_CH-1:0] output_mode_register_ff;
    logic [NUM_CH-1:0] output_level_register_ff;
    logic [NUM_CH-1:0] sw_val_wr;

    assign sw_val_wr = (wr_ok && reg_addr == `TMR_OUT_VAL) ? ~output_enable_register_ff : '0;

    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            output_value_register_ff <= '0;
        end else if (!unit_power_enable_ff) begin
            output_value_register_ff <= '0;
        end else begin
            // software writes bits not under timer control
            // toggle only on events, held otherwise
            output_value_register_ff <= ((output_value_register_ff & ~sw_val_wr) |
                (reg_wdata[NUM_CH-1:0] & sw_val_wr)) ^
                (ch_event & output_enable_register_ff);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            output_enable_register_ff <= '0;
            output_mode_register_ff <= '0;
            output_level_register_ff <= '0;
        end else if (!unit_power_enable_ff) begin
            output_enable_register_ff <= '0;
            output_mode_register_ff <= '0;
            output_level_register_ff <= '0;
        end else begin
            if (wr_ok && reg_addr == `TMR_OUT_EN) begin
                output_enable_register_ff <= reg_wdata[NUM_CH-1:0];
            end
            if (wr_ok && reg_addr == `TMR_OUT_MODE) begin
                output_mode_register_ff <= reg_wdata[NUM_CH-1:0];
            end
            if (wr_ok && reg_addr == `TMR_OUT_LVL) begin
                output_level_register_ff <= reg_wdata[NUM_CH-1:0];
            end
        end
    end

    // pin path: value bit through level inversion; port mode when unpowered
    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            timer_pin_out <= '0;
            timer_pin_oe <= '0;
        end else if (!unit_power_enable_ff) begin
            timer_pin_out <= '0;
            timer_pin_oe <= '0;
        end else begin
            timer_pin_out <= output_value_register_ff ^ output_level_register_ff;
            timer_pin_oe <= '1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            channel_interrupt <= '0;
        end else begin
            channel_interrupt <= ch_event;
        end
    end

    // ---------------------------------------------
    // read path
    // ---------------------------------------------
    logic [31:0] rd_val;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (reg_addr == `TMR_UNIT_CTRL) begin
            rd_val[`TMR_POWER_BIT] = unit_power_enable_ff;
        end else if (reg_addr == `TMR_PRESCALE) begin
            rd_val[7:0] = prescaler_select_register_ff;
        end else if (reg_addr == `TMR_ACTIVE) begin
            rd_val[NUM_CH-1:0] = channel_active_flag;
            rd_val[`TMR_UPPER_CH1_BIT] = channel_active_flag[1];
            rd_val[`TMR_UPPER_CH3_BIT] = channel_active_flag[3];
        end else if (reg_addr == `TMR_OUT_VAL) begin
            rd_val[NUM_CH-1:0] = output_value_register_ff;
        end else if (reg_addr == `TMR_OUT_EN) begin
            rd_val[NUM_CH-1:0] = output_enable_register_ff;
        end else if (reg_addr == `TMR_OUT_MODE) begin
            rd_val[NUM_CH-1:0] = output_mode_register_ff;
        end else if (reg_addr == `TMR_OUT_LVL) begin
            rd_val[NUM_CH-1:0] = output_level_register_ff;
        end else if (addr_lo_ok && grp == `TMR_GRP_MODE) begin
            rd_val[15:0] = mode_vec[sel_ch];
        end else if (addr_lo_ok && grp == `TMR_GRP_PERIOD) begin
            rd_val[CNT_W-1:0] = period_vec[sel_ch];
        end else if (addr_lo_ok && grp == `TMR_GRP_COUNT) begin
            rd_val[CNT_W-1:0] = cnt_vec[sel_ch];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
        end
    end

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n_ff);

    logic wr_start0;
    assign wr_start0 = wr_ok && reg_addr == `TMR_START && reg_wdata[0];

    power_off_idle_a: assert property (
        !unit_power_enable_ff |=> channel_active_flag == '0 && channel_interrupt == '0)
        else $error("channel active while unpowered");
    write_lock_a: assert property (
        !unit_power_enable_ff && reg_wr && reg_addr == `TMR_OUT_EN
        |=> output_enable_register_ff == '0)
        else $error("write accepted while unpowered");
    start_sets_a: assert property (
        wr_start0 |=> channel_active_flag[0])
        else $error("start did not activate channel");
    trigger_reads_zero_a: assert property (
        $past(reg_rd) && ($past(reg_addr) == `TMR_START || $past(reg_addr) == `TMR_STOP)
        |-> reg_rdata == '0)
        else $error("trigger register read not zero");
    stop_clears_a: assert property (
        wr_ok && reg_addr == `TMR_STOP && reg_wdata[0] |=> !channel_active_flag[0])
        else $error("stop did not clear active flag");
    counter_freeze_a: assert property (
        unit_power_enable_ff && !channel_active_flag[0] && !wr_start0
        ##1 unit_power_enable_ff |-> $stable(cnt_vec[0]))
        else $error("stopped counter moved");
    reload_zero_a: assert property (
        ch[0].state_ff == interval_timer_pkg::CH_RUN && ch[0].count_tick &&
        cnt_vec[0] == '0 && !stop_hit[0] && !start_hit[0]
        |=> cnt_vec[0] == $past(period_vec[0]) && channel_interrupt[0])
        else $error("reload or interrupt missing at zero");
    count_down_a: assert property (
        ch[0].state_ff == interval_timer_pkg::CH_RUN && ch[0].count_tick &&
        cnt_vec[0] != '0 && !stop_hit[0] && !start_hit[0]
        |=> cnt_vec[0] == $past(cnt_vec[0]) - 1'b1)
        else $error("counter did not decrement");
    toggle_event_a: assert property (
        ch_event[0] && output_enable_register_ff[0] && unit_power_enable_ff
        |=> output_value_register_ff[0] != $past(output_value_register_ff[0]))
        else $error("output not toggled on event");
    quiet_start_a: assert property (
        ch[1].state_ff == interval_timer_pkg::CH_LOAD &&
        !mode_vec[1][`TMR_MODE_SIM_BIT] |=> !channel_interrupt[1])
        else $error("interrupt on quiet first load");
    count_read_a: assert property (
        reg_rd && reg_addr == {`TMR_GRP_COUNT, 4'h0} |=> reg_rdata[CNT_W-1:0] == $past(cnt_vec[0]))
        else $error("counter read mismatch");
    pin_off_a: assert property (
        !unit_power_enable_ff |=> timer_pin_oe == '0 && output_value_register_ff == '0)
        else $error("pin not returned to port");

    start_seen_c: cover property (wr_start0 ##[1:20] channel_interrupt[0]);
    wrap_seen_c: cover property (channel_interrupt[0] ##[1:50] channel_interrupt[0]);
    stop_seen_c: cover property (channel_active_flag[0] ##1 !channel_active_flag[0]);
endmodule

`default_nettype wire

// ### hdl/interval_timer_map.svh
`ifndef INTERVAL_TIMER_MAP_SVH
`define INTERVAL_TIMER_MAP_SVH
// ---------------------------------------------
// register byte addresses
// ---------------------------------------------
`define TMR_UNIT_CTRL 8'h00
`define TMR_PRESCALE 8'h04
`define TMR_START 8'h40
`define TMR_STOP 8'h44
`define TMR_ACTIVE 8'h48
`define TMR_OUT_VAL 8'h4C
`define TMR_OUT_EN 8'h50
`define TMR_OUT_MODE 8'h54
`define TMR_OUT_LVL 8'h58
// per-channel groups: address[7:4] = group, address[3:2] = channel
`define TMR_GRP_MODE 4'h1
`define TMR_GRP_PERIOD 4'h2
`define TMR_GRP_COUNT 4'h3
// ---------------------------------------------
// field positions and reset values
// ---------------------------------------------
`define TMR_POWER_BIT 0
`define TMR_PS1_LSB 4
`define TMR_PS_W 4
`define TMR_MODE_SIM_BIT 0
`define TMR_MODE_CKS_BIT 15
`define TMR_UPPER_CH1_BIT 9
`define TMR_UPPER_CH3_BIT 11
`define TMR_REG16_RST 16'h0000
`define TMR_PS_RST 8'h00
`endif

// ### hdl/interval_timer_pkg.sv
package interval_timer_pkg;
    // one-hot channel states
    typedef enum logic [2:0] {
        CH_IDLE = 3'h1,
        CH_LOAD = 3'h2,
        CH_RUN = 3'h4
    } ch_state_e;
endpackage

// ### verif/test_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_map.svh"

module test_interval_timer;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0] channel_interrupt;
    logic [3:0] timer_pin_out;
    logic [3:0] timer_pin_oe;
    int bad_count = 0;
    int check_count = 0;
    int n;
    logic [31:0] d;
    logic [31:0] d2;
    logic [3:0] p0;

    always #5 sys_clk = ~sys_clk;

    interval_timer #(.NUM_CH(4), .CNT_W(16)) uut (
        .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .channel_interrupt(channel_interrupt), .timer_pin_out(timer_pin_out),
        .timer_pin_oe(timer_pin_oe)
    );

    // ---------------------------------------------
    // checking and bus tasks
    // ---------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_num(input int got, input int lo, input int hi, input string what);
        check_count++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("Error %0t: %s took %0d cycles", $time, what, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk_reg(v, exp, "register read");
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask

    // counts cycles up to and including the next interrupt pulse
    task automatic wait_irq(input int ch, input int maxc, output int cnt);
        cnt = 0;
        do begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end while (channel_interrupt[ch] !== 1'b1 && cnt < maxc);
        if (channel_interrupt[ch] !== 1'b1) begin
            bad_count++;
            $display("Error %0t: no interrupt on channel %0d", $time, ch);
            end_sim();
        end
    endtask

    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic t_power_on;
        chk_pin(timer_pin_oe, 4'h0, "pin enable off");
        wr(8'h20, 32'h0000_0005);
        wr(`TMR_OUT_VAL, 32'h0000_0001);
        wr(`TMR_OUT_EN, 32'h0000_0001);
        wr(`TMR_UNIT_CTRL, 32'h0000_0001);
        rd_chk(`TMR_OUT_EN, 32'h0000_0000);
        rd_chk(8'h20, 32'h0000_0000);
        rd_chk(`TMR_OUT_VAL, 32'h0000_0000);
        rd_chk(`TMR_ACTIVE, 32'h0000_0000);
        chk_pin(timer_pin_oe, 4'hF, "pin enable on");
    endtask

    task automatic t_preset;
        wr(8'h10, 32'h0000_0001);
        wr(8'h20, 32'h0000_0005);
        wr(`TMR_OUT_MODE, 32'h0000_0000);
        wr(`TMR_OUT_LVL, 32'h0000_0000);
        wr(`TMR_OUT_VAL, 32'h0000_0005);
        idle(2);
        chk_pin(timer_pin_out, 4'h5, "pin follows value");
        wr(`TMR_OUT_EN, 32'h0000_0001);
        wr(`TMR_OUT_VAL, 32'h0000_0000);
        idle(3);
        chk_pin(timer_pin_out, 4'h1, "enabled pin holds preset");
        chk_pin(channel_interrupt, 4'h0, "no event while stopped");
    endtask

    task automatic t_run;
        wr(`TMR_START, 32'h0000_0001);
        wait_irq(0, 10, n);
        chk_num(n, 1, 3, "first load event");
        idle(2);
        chk_pin(timer_pin_out, 4'h0, "toggle at first load");
        for (int k = 0; k < 2; k++) begin
            wait_irq(0, 10, n);
            chk_num(n, 4, 4, "interval period+1");
            idle(2);
            chk_pin(timer_pin_out, (k == 0) ? 4'h1 : 4'h0, "square wave");
        end
        rd(8'h30, d);
        chk_reg({d[31:3], 3'b000}, 32'h0000_0000, "counter in range");
        rd_chk(`TMR_ACTIVE, 32'h0000_0001);
        rd_chk(`TMR_START, 32'h0000_0000);
    endtask

    task automatic t_period_change;
        wait_irq(0, 10, n);
        wr(8'h20, 32'h0000_0009);
        wait_irq(0, 10, n);
        chk_num(n, 3, 5, "old period kept");
        wait_irq(0, 14, n);
        chk_num(n, 10, 10, "new period used");
        rd_chk(8'h20, 32'h0000_0009);
    endtask

    task automatic t_stop;
        wait_irq(0, 14, n);
        idle(2);
        p0 = timer_pin_out;
        wr(`TMR_STOP, 32'h0000_0001);
        rd(8'h30, d);
        idle(15);
        rd(8'h30, d2);
        chk_reg(d2, d, "counter frozen");
        chk_pin(timer_pin_out, p0, "pin kept on stop");
        rd_chk(`TMR_ACTIVE, 32'h0000_0000);
        rd_chk(`TMR_STOP, 32'h0000_0000);
    endtask

    task automatic t_multi;
        wr(8'h24, 32'h0000_0005);
        wr(`TMR_START, 32'h0000_0200);
        wait_irq(1, 20, n);
        chk_num(n, 5, 9, "quiet first load");
        wr(`TMR_START, 32'h0000_000C);
        rd(`TMR_ACTIVE, d);
        chk_reg(d & 32'h0000_000E, 32'h0000_000E, "grouped start");
        wr(`TMR_STOP, 32'h0000_0A0F);
        rd_chk(`TMR_ACTIVE, 32'h0000_0000);
    endtask

    task automatic t_power_off;
        wr(`TMR_OUT_EN, 32'h0000_0000);
        wr(`TMR_OUT_VAL, 32'h0000_0000);
        idle(2);
        chk_pin(timer_pin_out, 4'h0, "value cleared before shutdown");
        wr(`TMR_UNIT_CTRL, 32'h0000_0000);
        idle(3);
        chk_pin(timer_pin_oe, 4'h0, "port mode");
        chk_pin(timer_pin_out, 4'h0, "pin cleared");
        wr(`TMR_UNIT_CTRL, 32'h0000_0001);
        rd_chk(8'h20, 32'h0000_0000);
        rd_chk(8'h10, 32'h0000_0000);
        rd_chk(8'h30, 32'h0000_0000);
        rd_chk(`TMR_OUT_EN, 32'h0000_0000);
        rd_chk(`TMR_OUT_VAL, 32'h0000_0000);
    endtask

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_power_on();
        t_preset();
        t_run();
        t_period_change();
        t_stop();
        t_multi();
        t_power_off();
        end_sim();
    end
endmodule

`default_nettype wire
